// ===== src/irtl_defines.svh
// Purpose: Offsets, field positions, reset values of the limit/coeff bank
// Assumes: 16-bit register words, byte-wide register pointer
// Notes:   Definitions only
`ifndef IRTL_DEFINES_SVH
`define IRTL_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define IRTL_OFS_OBJ_HIGH 8'h06
`define IRTL_OFS_OBJ_LOW 8'h07
`define IRTL_OFS_DIE_HIGH 8'h08
`define IRTL_OFS_DIE_LOW 8'h09
`define IRTL_OFS_SENS 8'h0a
`define IRTL_OFS_DIE_LIN 8'h0b
`define IRTL_OFS_DIE_QUAD 8'h0c
`define IRTL_OFS_OFF_CONST 8'h0d
`define IRTL_OFS_OFF_LIN 8'h0e
`define IRTL_OFS_OFF_QUAD 8'h0f
`define IRTL_OFS_SEEBECK 8'h10
`define IRTL_OFS_TR_GAIN 8'h11
`define IRTL_OFS_TR_SLOPE 8'h12

// ----------------------------------------------------------------------
// Threshold field layout
// ----------------------------------------------------------------------
`define IRTL_THR_MSB 15
`define IRTL_THR_LSB 6
`define IRTL_THR_W 10
`define IRTL_THR_PAD 6'h00

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IRTL_RST_HIGH 16'h7fc0
`define IRTL_RST_LOW 16'h8000
`define IRTL_RST_SENS 16'h260e
`define IRTL_RST_DIE_LIN 16'h0106
`define IRTL_RST_DIE_QUAD 16'hff9b
`define IRTL_RST_OFF_CONST 16'hff3a
`define IRTL_RST_OFF_LIN 16'hff71
`define IRTL_RST_OFF_QUAD 16'h0553
`define IRTL_RST_SEEBECK 16'h0000
`define IRTL_RST_TR_GAIN 16'h0034
`define IRTL_RST_TR_SLOPE 16'h0000

`endif

// ===== src/irtl_pkg.sv
// Purpose: Types shared by the limit/coeff bank modules
// Assumes: irtl_defines.svh for the threshold width
// Notes:   Types only
`include "irtl_defines.svh"

package irtl_pkg;

    typedef struct packed {
        logic [`IRTL_THR_W-1:0] field;
    } irtl_limit_state_t;

    typedef struct packed {
        logic [8:0][15:0] coeff;
        logic [15:0] rdData;
        logic rdValid;
        logic rdLimit;
        logic objHigh;
        logic dieLow;
        logic pristine;
    } irtl_bank_state_t;

endpackage

// ===== src/irtl_limit_reg.sv
// Purpose: One alarm limit register, 10-bit threshold in the top bits
// Assumes: Write strobe already decoded for this register
// Notes:   Low six bits are never stored
`timescale 1ns/1ns
`default_nettype none
`include "irtl_defines.svh"

module irtl_limit_reg
    import irtl_pkg::*;
#(
    parameter logic [15:0] RESET_VAL = `IRTL_RST_HIGH
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wrEn,
    input wire logic [15:0] wrData,
    output logic [15:0] limitOut
);

    irtl_limit_state_t state_q;
    irtl_limit_state_t state_d;

    always_comb begin
        state_d = state_q;
        if (wrEn) begin
            state_d.field = wrData[`IRTL_THR_MSB:`IRTL_THR_LSB]; // RULE20
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q.field <= RESET_VAL[`IRTL_THR_MSB:`IRTL_THR_LSB];
        end else begin
            state_q <= state_d;
        end
    end

    assign limitOut = {state_q.field, `IRTL_THR_PAD}; // RULE3

endmodule

`default_nettype wire

// ===== src/irtl_cmp.sv
// Purpose: Signed threshold compare of a result word against a limit
// Assumes: Both words aligned 16-bit two's complement
// Notes:   ABOVE=1 tests result > limit, ABOVE=0 tests result < limit
`timescale 1ns/1ns
`default_nettype none

module irtl_cmp
    import irtl_pkg::*;
#(
    parameter bit ABOVE = 1'b1
) (
    input wire logic [15:0] resultWord,
    input wire logic [15:0] limitWord,
    output logic violated
);

    always_comb begin
        if (ABOVE) begin
            violated = $signed(resultWord) > $signed(limitWord); // RULE19
        end else begin
            violated = $signed(resultWord) < $signed(limitWord); // RULE19
        end
    end

endmodule

`default_nettype wire

// ===== src/irtl_regs.sv
// Purpose: Alarm limit and calibration coefficient register bank
// Assumes: Serial interface decodes frames into word strobes
// Notes:   Coefficients feed the math engine straight from flops
//
// What this block does
// RULE1 - Object limits: signed 10-bit, half degree steps
// RULE2 - Die limits: signed 10-bit, half degree steps
// RULE3 - Limit low six bits read zero
// RULE4 - Object high limit resets to 7fc0
// RULE5 - Object low limit resets to 8000
// RULE6 - Die high limit resets to 7fc0
// RULE7 - Die low limit resets to 8000
// RULE8 - Coefficients drive math engine directly
// RULE9 - Host retunes transient coefficients per mode
// RULE10 - Sensitivity coefficient 16-bit, resets 260e
// RULE11 - Die linear coefficient resets to 0106
// RULE12 - Die quadratic coefficient resets to ff9b
// RULE13 - Constant offset coefficient resets to ff3a
// RULE14 - Linear offset coefficient resets to ff71
// RULE15 - Quadratic offset coefficient resets to 0553
// RULE16 - Signed coefficients are two's complement
// RULE17 - Object high flag on result above limit
// RULE18 - Die low flag on result below limit
// RULE19 - Compare aligned 16-bit signed words
// RULE20 - Limit low-bit writes are discarded
`timescale 1ns/1ns
`default_nettype none
`include "irtl_defines.svh"

module irtl_regs
    import irtl_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    output logic [DATA_W-1:0] regRdData,
    output logic regRdValid,
    input wire logic convDone,
    input wire logic [15:0] objectResult,
    input wire logic [15:0] dieResult,
    input wire logic compMode,
    input wire logic statusRead,
    output logic objectHighFlag,
    output logic dieLowFlag,
    output logic [15:0] objectHighLimit,
    output logic [15:0] objectLowLimit,
    output logic [15:0] dieHighLimit,
    output logic [15:0] dieLowLimit,
    output logic [15:0] sensitivityCoeff,
    output logic signed [15:0] dieLinearCoeff,
    output logic signed [15:0] dieQuadraticCoeff,
    output logic signed [15:0] offsetConstCoeff,
    output logic signed [15:0] offsetLinearCoeff,
    output logic signed [15:0] offsetQuadraticCoeff,
    output logic signed [15:0] seebeckQuadraticCoeff,
    output logic signed [15:0] transientGainCoeff,
    output logic signed [15:0] transientSlopeCoeff
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (ADDR_W != 8) begin : gBadAddr
        $error("irtl_regs: register pointer must be 8 bits");
    end
    if (DATA_W != 16) begin : gBadData
        $error("irtl_regs: register words must be 16 bits");
    end

    // ------------------------------------------------------------------
    // Coefficient reset values by index from the first coefficient
    // ------------------------------------------------------------------
    function automatic logic [15:0] coeffReset(input int idx);
        logic [15:0] val;
        val = 16'h0000;
        case (idx)
            0: val = `IRTL_RST_SENS; // RULE10
            1: val = `IRTL_RST_DIE_LIN; // RULE11
            2: val = `IRTL_RST_DIE_QUAD; // RULE12
            3: val = `IRTL_RST_OFF_CONST; // RULE13
            4: val = `IRTL_RST_OFF_LIN; // RULE14
            5: val = `IRTL_RST_OFF_QUAD; // RULE15
            6: val = `IRTL_RST_SEEBECK;
            7: val = `IRTL_RST_TR_GAIN;
            8: val = `IRTL_RST_TR_SLOPE;
            default: val = 16'h0000;
        endcase
        return val;
    endfunction

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    logic [7:0] coeffOfs;
    logic [3:0] coeffIdx;
    logic inCoeff;
    logic [7:0] limitOfs;
    logic [1:0] limitIdx;
    logic inLimit;

    assign coeffOfs = regAddr - `IRTL_OFS_SENS;
    assign coeffIdx = coeffOfs[3:0];
    assign inCoeff = (regAddr >= `IRTL_OFS_SENS) &&
                     (regAddr <= `IRTL_OFS_TR_SLOPE);
    assign limitOfs = regAddr - `IRTL_OFS_OBJ_HIGH;
    assign limitIdx = limitOfs[1:0];
    assign inLimit = (regAddr >= `IRTL_OFS_OBJ_HIGH) &&
                     (regAddr <= `IRTL_OFS_DIE_LOW);

    // ------------------------------------------------------------------
    // Limit registers: high limits on even offsets, low on odd
    // ------------------------------------------------------------------
    logic [3:0][15:0] limitVal;

    for (genvar i = 0; i < 4; i++) begin : gLimit
        irtl_limit_reg #(
            .RESET_VAL((i % 2 == 0) ? `IRTL_RST_HIGH : `IRTL_RST_LOW)
        ) uLimit (
            .sys_clk(sys_clk),
            .reset_n(reset_n),
            .wrEn(regWrEn && inLimit && (limitIdx == 2'(i))),
            .wrData(regWrData),
            .limitOut(limitVal[i])
        ); // RULE1 RULE2 RULE4 RULE5 RULE6 RULE7
    end

    assign objectHighLimit = limitVal[0];
    assign objectLowLimit = limitVal[1];
    assign dieHighLimit = limitVal[2];
    assign dieLowLimit = limitVal[3];

    // ------------------------------------------------------------------
    // Threshold comparators
    // ------------------------------------------------------------------
    logic objAbove;
    logic dieBelow;

    irtl_cmp #(.ABOVE(1'b1)) uObjHigh (
        .resultWord(objectResult),
        .limitWord(objectHighLimit),
        .violated(objAbove)
    );

    irtl_cmp #(.ABOVE(1'b0)) uDieLow (
        .resultWord(dieResult),
        .limitWord(dieLowLimit),
        .violated(dieBelow)
    );

    // ------------------------------------------------------------------
    // Bank state
    // ------------------------------------------------------------------
    irtl_bank_state_t state_q;
    irtl_bank_state_t state_d;

    always_comb begin
        state_d = state_q;
        state_d.rdValid = regRdEn;
        state_d.rdLimit = regRdEn && inLimit;
        if (regRdEn) begin
            if (inLimit) begin
                state_d.rdData = limitVal[limitIdx]; // RULE3
            end else if (inCoeff) begin
                state_d.rdData = state_q.coeff[coeffIdx];
            end else begin
                state_d.rdData = 16'h0000;
            end
        end
        if (regWrEn && (inCoeff || inLimit)) begin
            state_d.pristine = 1'b0;
        end
        if (regWrEn && inCoeff) begin
            state_d.coeff[coeffIdx] = regWrData; // RULE8
        end
        // Comparator mode follows each conversion; latched mode holds
        // until a status read, and a fresh violation beats the clear
        if (compMode) begin
            if (convDone) begin
                state_d.objHigh = objAbove; // RULE17
                state_d.dieLow = dieBelow; // RULE18
            end
        end else begin
            if (statusRead) begin
                state_d.objHigh = 1'b0;
                state_d.dieLow = 1'b0;
            end
            if (convDone && objAbove) begin
                state_d.objHigh = 1'b1; // RULE17
            end
            if (convDone && dieBelow) begin
                state_d.dieLow = 1'b1; // RULE18
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int k = 0; k < 9; k++) begin
                state_q.coeff[k] <= coeffReset(k);
            end
            state_q.rdData <= 16'h0000;
            state_q.rdValid <= 1'b0;
            state_q.rdLimit <= 1'b0;
            state_q.objHigh <= 1'b0;
            state_q.dieLow <= 1'b0;
            state_q.pristine <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign regRdData = state_q.rdData;
    assign regRdValid = state_q.rdValid;
    assign objectHighFlag = state_q.objHigh;
    assign dieLowFlag = state_q.dieLow;
    assign sensitivityCoeff = state_q.coeff[0];
    // Signed views for the math engine
    assign dieLinearCoeff = $signed(state_q.coeff[1]); // RULE16
    assign dieQuadraticCoeff = $signed(state_q.coeff[2]); // RULE16
    assign offsetConstCoeff = $signed(state_q.coeff[3]); // RULE16
    assign offsetLinearCoeff = $signed(state_q.coeff[4]); // RULE16
    assign offsetQuadraticCoeff = $signed(state_q.coeff[5]); // RULE16
    assign seebeckQuadraticCoeff = $signed(state_q.coeff[6]); // RULE16
    // Transient pair resets to the four-average tuning
    assign transientGainCoeff = $signed(state_q.coeff[7]); // RULE9
    assign transientSlopeCoeff = $signed(state_q.coeff[8]); // RULE9

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cbClk @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence sLimitWrite;
        regWrEn && inLimit;
    endsequence

    sequence sLimitReadBack;
        regRdEn && (regAddr == $past(regAddr, 2)) ##1 regRdValid;
    endsequence

    obj_high_set_a: assert property ( // RULE17
        convDone && objAbove |=> objectHighFlag [*1]
    ) else $error("object high flag missed a violation");

    die_low_set_a: assert property ( // RULE18
        convDone && dieBelow |=> dieLowFlag
    ) else $error("die low flag missed a violation");

    latched_hold_a: assert property ( // RULE17
        !compMode && objectHighFlag && !statusRead |=> objectHighFlag
    ) else $error("latched object high flag dropped");

    comp_clear_a: assert property ( // RULE18
        compMode && convDone && !dieBelow |=> !dieLowFlag
    ) else $error("comparator die low flag not cleared");

    limit_pad_a: assert property ( // RULE3
        regRdValid && state_q.rdLimit |-> regRdData[5:0] == 6'h00
    ) else $error("limit low bits read nonzero");

    limit_drop_a: assert property ( // RULE20
        sLimitWrite ##1 !regWrEn ##1 sLimitReadBack |->
            regRdData[15:6] == $past(regWrData[15:6], 3)
    ) else $error("limit write not stored in upper bits");

    limit_reset_a: assert property ( // RULE4
        state_q.pristine |-> objectHighLimit == `IRTL_RST_HIGH &&
            objectLowLimit == `IRTL_RST_LOW &&
            dieHighLimit == `IRTL_RST_HIGH &&
            dieLowLimit == `IRTL_RST_LOW
    ) else $error("limit reset value wrong");

    coeff_reset_a: assert property ( // RULE10
        state_q.pristine |-> sensitivityCoeff == `IRTL_RST_SENS &&
            offsetQuadraticCoeff == `IRTL_RST_OFF_QUAD &&
            transientGainCoeff == `IRTL_RST_TR_GAIN
    ) else $error("coefficient reset value wrong");

    coeff_write_a: assert property ( // RULE8
        regWrEn && regAddr == `IRTL_OFS_DIE_QUAD |=>
            dieQuadraticCoeff == $past(regWrData)
    ) else $error("coefficient write not seen by engine");

    unmapped_zero_a: assert property ( // Unmapped reads return zero
        regRdEn && !inLimit && !inCoeff |=> regRdData == 16'h0000
    ) else $error("unmapped read not zero");

endmodule

`default_nettype wire

// ===== test/irtl_host_model.sv
// Purpose: Host side of the word strobe register port
// Assumes: One word per strobe, requests launched just after a rising edge
// Notes:   Released address and data lines show the inverse of the last value
`timescale 1ns/1ns
`default_nettype none

module irtl_host_model (
    input wire logic sys_clk,
    output logic regWrEn,
    output logic regRdEn,
    output logic [7:0] regAddr,
    output logic [15:0] regWrData
);
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 16'h0000;
    end

    task automatic write_word(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask

    task automatic read_word(input logic [7:0] a);
        @(posedge sys_clk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
    endtask

    // On a mode switch the gain word is written first, then the slope word two cycles later
    task automatic retune_transient(input logic [15:0] g, input logic [15:0] s);
        write_word(8'h11, g);
        write_word(8'h12, s);
    endtask
endmodule

`default_nettype wire

// ===== test/irtl_regs_tb.sv
// Purpose: Self-checking bench of the limit and coefficient bank
// Assumes: Read answers arrive in request order
// Notes:   A mirror array holds what each register should read back
`timescale 1ns/1ns
`default_nettype none

module irtl_regs_tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic regWrEn, regRdEn, regRdValid, objectHighFlag, dieLowFlag;
    logic [7:0] regAddr;
    logic [15:0] regWrData, regRdData;
    logic convDone = 1'b0;
    logic compMode = 1'b1;
    logic statusRead = 1'b0;
    logic [15:0] objectResult = 16'h0000;
    logic [15:0] dieResult = 16'h0000;
    logic [15:0] portVal [13];
    logic [15:0] mirror [13];
    logic [15:0] expQ [$];
    logic [15:0] o, d;
    int failCount = 0;
    int nCompared = 0;
    const logic [15:0] rstTab [13] = '{16'h7fc0, 16'h8000, 16'h7fc0,
        16'h8000, 16'h260e, 16'h0106, 16'hff9b, 16'hff3a, 16'hff71,
        16'h0553, 16'h0000, 16'h0034, 16'h0000};

    initial forever #5 sys_clk = ~sys_clk;

    irtl_host_model irtl_host_model_inst (.sys_clk(sys_clk),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData));

    irtl_regs irtl_regs_inst (.sys_clk(sys_clk), .reset_n(reset_n),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData),
        .regRdValid(regRdValid), .convDone(convDone),
        .objectResult(objectResult), .dieResult(dieResult),
        .compMode(compMode), .statusRead(statusRead),
        .objectHighFlag(objectHighFlag), .dieLowFlag(dieLowFlag),
        .objectHighLimit(portVal[0]), .objectLowLimit(portVal[1]),
        .dieHighLimit(portVal[2]), .dieLowLimit(portVal[3]),
        .sensitivityCoeff(portVal[4]), .dieLinearCoeff(portVal[5]),
        .dieQuadraticCoeff(portVal[6]), .offsetConstCoeff(portVal[7]),
        .offsetLinearCoeff(portVal[8]),
        .offsetQuadraticCoeff(portVal[9]),
        .seebeckQuadraticCoeff(portVal[10]),
        .transientGainCoeff(portVal[11]),
        .transientSlopeCoeff(portVal[12]));

    // ------------------------------------------------------------------
    // Comparison and bus helpers
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Limit words keep only the 10-bit threshold field
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        irtl_host_model_inst.write_word(a, v);
        if (a >= 8'h06 && a <= 8'h09) mirror[a - 8'h06] = v & 16'hffc0;
        else if (a >= 8'h0a && a <= 8'h12) mirror[a - 8'h06] = v;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        expQ.push_back(exp);
        irtl_host_model_inst.read_word(a);
    endtask

    task automatic chk_all();
        for (int i = 0; i < 13; i++) begin
            rd(8'h06 + i[7:0], mirror[i]);
            check(portVal[i], mirror[i], "register port");
        end
    endtask

    task automatic conv(input logic [15:0] ov, input logic [15:0] dv);
        @(posedge sys_clk);
        convDone <= 1'b1;
        objectResult <= ov;
        dieResult <= dv;
        @(posedge sys_clk);
        convDone <= 1'b0;
        objectResult <= ~ov;
        dieResult <= ~dv;
        @(negedge sys_clk);
    endtask

    task automatic flags(input logic oh, input logic dl);
        check({15'h0, objectHighFlag}, {15'h0, oh}, "object high flag");
        check({15'h0, dieLowFlag}, {15'h0, dl}, "die low flag");
    endtask

    // Answers are compared oldest first as they appear
    always @(posedge sys_clk) begin
        if (regRdValid === 1'b1) begin
            if (expQ.size() == 0) check(regRdData, 16'hxxxx, "stray answer");
            else check(regRdData, expQ.pop_front(), "read word");
        end
    end

    initial begin
        #100000;
        failCount++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h896c));
        mirror = rstTab;
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'b1;
        chk_all();
        wr(8'h13, 16'h5a5a);
        rd(8'h13, 16'h0000);
        rd(8'hff, 16'h0000);
        for (int i = 0; i < 13; i++) wr(8'h06 + i[7:0], 16'($urandom));
        wr(8'h06, 16'h803f);
        wr(8'h08, 16'h7fff);
        rd(8'h08, 16'h7fc0);
        chk_all();
        irtl_host_model_inst.retune_transient(16'h1234, 16'hfedc);
        mirror[11] = 16'h1234;
        mirror[12] = 16'hfedc;
        chk_all();
        wr(8'h06, 16'h123f);
        wr(8'h09, 16'hf3ff);
        conv(16'h1201, 16'hf3bf);
        flags(1'b1, 1'b1);
        conv(16'h1200, 16'hf3c0);
        flags(1'b0, 1'b0);
        for (int i = 0; i < 24; i++) begin
            wr(8'h06, 16'($urandom));
            wr(8'h09, 16'($urandom));
            o = 16'($urandom);
            d = 16'($urandom);
            conv(o, d);
            flags($signed(o) > $signed(mirror[0]), $signed(d) < $signed(mirror[3]));
        end
        wr(8'h06, 16'h1200);
        wr(8'h09, 16'hf3c0);
        // Clear both flags in comparator mode before latching starts
        conv(16'h1200, 16'hf3c0);
        flags(1'b0, 1'b0);
        @(posedge sys_clk);
        compMode <= 1'b0;
        conv(16'h1300, 16'h0000);
        flags(1'b1, 1'b0);
        conv(16'h0000, 16'h8000);
        flags(1'b1, 1'b1);
        @(posedge sys_clk);
        statusRead <= 1'b1;
        @(posedge sys_clk);
        statusRead <= 1'b0;
        @(negedge sys_clk);
        flags(1'b0, 1'b0);
        // A violation and a status read in one cycle: the set wins
        fork
            conv(16'h1300, 16'h0000);
            begin
                @(posedge sys_clk);
                statusRead <= 1'b1;
                @(posedge sys_clk);
                statusRead <= 1'b0;
            end
        join
        flags(1'b1, 1'b0);
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        mirror = rstTab;
        chk_all();
        for (int i = 0; i < 20 && expQ.size() > 0; i++) @(posedge sys_clk);
        if (expQ.size() != 0) check(16'h0000, 16'hffff, "missing answer");
        tally_and_finish();
    end
endmodule

`default_nettype wire
